// ---- shared/ppmc_map.vh ----
`ifndef PPMC_MAP_VH
`define PPMC_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPMC_OFF_BCTL     12'h000
`define PPMC_OFF_EDPD     12'h004
`define PPMC_OFF_SPDCTL   12'h008
`define PPMC_OFF_XTAL     12'h00c
`define PPMC_OFF_REG      12'h010
`define PPMC_OFF_COMMON   12'h014
`define PPMC_OFF_STATUS   12'h018
`define PPMC_OFF_ACCESS   12'h01c
// ----------------------------------------
// field positions
// ----------------------------------------
`define PPMC_BCTL_AN      12
`define PPMC_BCTL_PD      11
`define PPMC_BCTL_ISO     10
`define PPMC_EDPD_EN      0
`define PPMC_EDPD_RAND    1
`define PPMC_EDPD_MASK_LO 2
`define PPMC_EDPD_TMR_LO  4
`define PPMC_SPD_OVR      0
`define PPMC_SPD_PLL      1
`define PPMC_XTAL_DIS     0
`define PPMC_REG_EN_N     0
`define PPMC_COM_CLK125   0
// ----------------------------------------
// reset values
// ----------------------------------------
`define PPMC_BCTL_RST     16'h1000
`define PPMC_EDPD_RST     8'h00
`define PPMC_COM_RST      1'b1
`define PPMC_STRAP_SLEEP  4'h7
// ----------------------------------------
// timing and thresholds
// ----------------------------------------
`define PPMC_CLK_MHZ      125
`define PPMC_PULSE_US     16
`define PPMC_PULSE_CYC    (`PPMC_PULSE_US * `PPMC_CLK_MHZ)
`define PPMC_SHORT_M      8'd70
// access space codes
`define PPMC_SPACE_STD    2'd0
`define PPMC_SPACE_MMD1   2'd1
`define PPMC_SPACE_MMDX   2'd2
`endif

// ---- verilog/ppmc_power_ctrl.v ----
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "ppmc_map.vh"
// Overview of operation
// - edpd needs enable, autoneg, no link
// - edpd keeps transmitter, detector, pulses, clocks; stops rx blocks
// - edpd enable clear after reset
// - leaving edpd keeps registers
// - mask, interval timers, random disable fields
// - software power-down follows control bit
// - spd gates internal clocks, pll runs
// - spd allows standard registers only
// - override ungates clocks, allows space two only
// - space one refused during spd
// - registers kept unless pll disabled
// - tx rx clocks stop; isolate stops
// - reference clock stops unless override, enabled
// - pll disable: stop pll, reset exit
// - crystal disable after pll, spd; locks
// - regulator off when enable-low bit set
// - strap 0111 gives permanent chip sleep
// - short cable reduces adc, taps
module ppmc_power_ctrl
(
   input  wire        clk,
   input  wire        sys_rst,
   // axi4-lite slave
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // line and strap inputs
   input  wire        link_up,
   input  wire        energy_seen,
   input  wire [3:0]  mode_strap,
   input  wire [7:0]  cable_len_m,
   // power controls
   output reg         tx_block_en,
   output reg         rx_blocks_en,
   output reg         link_pulse,
   output reg         int_clk_en,
   output reg         pll_en,
   output reg         xtal_en,
   output reg         txrx_clk_en,
   output reg         reference_clock_out_en,
   output reg         core_regulator_controller_en,
   output reg         low_power_dsp,
   output reg         strap_chip_sleep,
   output reg         edpd_active
);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [1:0] link_s1_q, link_s2_q;
   reg [3:0] strap_s1_q, strap_s2_q;
   reg [7:0] len_s1_q, len_s2_q;
   wire      link_sync = link_s2_q[1];
   wire      energy_sync = link_s2_q[0];

   // two flops on every line and strap input
   always @(posedge clk)
   begin
      link_s1_q  <= {link_up, energy_seen};
      link_s2_q  <= link_s1_q;
      strap_s1_q <= mode_strap;
      strap_s2_q <= strap_s1_q;
      len_s1_q   <= cable_len_m;
      len_s2_q   <= len_s1_q;
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   reg [15:0] bctl_q;
   reg [7:0]  edpd_q;
   reg [1:0]  spd_q;
   reg        xtal_dis_q;
   reg        reg_en_n_q;
   reg        clk125_en_q;
   reg [1:0]  space_q;
   reg        refused_q;
   reg        soft_rst_q;
   reg        strap_taken_q;
   reg [1:0]  settle_q;
   reg        pd_seen_q;
   reg        pll_off_q;
   wire spd_on = bctl_q[`PPMC_BCTL_PD];
   wire ovr    = spd_q[`PPMC_SPD_OVR];
   wire locked = strap_chip_sleep | xtal_dis_q;
   // ----------------------------------------
   // axi4-lite handshake
   // ----------------------------------------
   reg        aw_q, w_q, ar_q;
   reg [11:0] awaddr_q, araddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg [31:0] rd_mux;
   reg        rd_hit;
   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
   assign s_axi_arready = ~ar_q & ~s_axi_rvalid;
   wire wr_go = aw_q & w_q & ~s_axi_bvalid;
   wire rd_go = ar_q & ~s_axi_rvalid;
   // which space a register lives in
   function [1:0] space_of;
      input [11:0] a;
      begin
         if (a == `PPMC_OFF_BCTL)
            space_of = `PPMC_SPACE_STD;
         else if (a == `PPMC_OFF_EDPD)
            space_of = `PPMC_SPACE_MMDX;
         else if (a == `PPMC_OFF_SPDCTL || a == `PPMC_OFF_REG)
            space_of = `PPMC_SPACE_MMD1;
         else
            space_of = `PPMC_SPACE_STD;
      end
   endfunction
   // access gate during software power-down
   function allowed;
      input [11:0] a;
      input        pd;
      input        ov;
      reg   [1:0]  s;
      begin
         s = space_of(a);
         if (!pd)
            allowed = 1'b1;
         else if (s == `PPMC_SPACE_MMD1)
            allowed = 1'b0;
         else if (s == `PPMC_SPACE_MMDX)
            allowed = ov;
         else
            allowed = 1'b1;
      end
   endfunction
   wire wr_ok = allowed(awaddr_q, spd_on, ovr) & ~locked;
   wire rd_ok = allowed(araddr_q, spd_on, ovr) & ~locked & rd_hit;
   wire wr_hit = (awaddr_q <= `PPMC_OFF_ACCESS); // aligned map is contiguous
   wire wr_do = wr_go & wr_ok & wr_hit;

   // capture address and data channels independently
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         ar_q         <= 1'b0;
         awaddr_q     <= 12'h000;
         araddr_q     <= 12'h000;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q     <= 1'b1;
            awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ok && wr_hit) ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            ar_q     <= 1'b1;
            araddr_q <= {s_axi_araddr[11:2], 2'b00};
         end
         if (rd_go)
         begin
            ar_q         <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always @*
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (araddr_q == `PPMC_OFF_BCTL)
         rd_mux = {16'h0000, bctl_q};
      else if (araddr_q == `PPMC_OFF_EDPD)
         rd_mux = {24'h000000, edpd_q};
      else if (araddr_q == `PPMC_OFF_SPDCTL)
         rd_mux = {30'h0, spd_q};
      else if (araddr_q == `PPMC_OFF_XTAL)
         rd_mux = {31'h0, xtal_dis_q};
      else if (araddr_q == `PPMC_OFF_REG)
         rd_mux = {31'h0, reg_en_n_q};
      else if (araddr_q == `PPMC_OFF_COMMON)
         rd_mux = {31'h0, clk125_en_q};
      else if (araddr_q == `PPMC_OFF_STATUS)
         rd_mux = {24'h0, strap_s2_q, low_power_dsp, edpd_active, spd_on, strap_chip_sleep};
      else if (araddr_q == `PPMC_OFF_ACCESS)
         rd_mux = {29'h0, space_q, refused_q};
      else
         rd_hit = 1'b0;
   end
   // ----------------------------------------
   // register writes and power-down reset
   // ----------------------------------------
   wire full_rst = sys_rst | soft_rst_q;
   always @(posedge clk)
   begin
      if (full_rst)
      begin
         bctl_q      <= `PPMC_BCTL_RST;
         edpd_q      <= `PPMC_EDPD_RST;
         spd_q       <= 2'b00;
         reg_en_n_q  <= 1'b0;
         clk125_en_q <= `PPMC_COM_RST;
      end
      else if (wr_do && wstrb_q[0] | wstrb_q[1])
      begin
         if (awaddr_q == `PPMC_OFF_BCTL)
            bctl_q <= wdata_q[15:0];
         else if (awaddr_q == `PPMC_OFF_EDPD)
            edpd_q <= wdata_q[7:0];
         else if (awaddr_q == `PPMC_OFF_SPDCTL)
            spd_q <= wdata_q[1:0];
         else if (awaddr_q == `PPMC_OFF_REG)
            reg_en_n_q <= wdata_q[`PPMC_REG_EN_N];
         else if (awaddr_q == `PPMC_OFF_COMMON)
            clk125_en_q <= wdata_q[`PPMC_COM_CLK125];
      end
   end
   // crystal disable only once pll is off and spd entered
   always @(posedge clk)
   begin
      if (sys_rst)
         xtal_dis_q <= 1'b0;
      else if (wr_do && awaddr_q == `PPMC_OFF_XTAL && pll_off_q && spd_on)
         xtal_dis_q <= wdata_q[`PPMC_XTAL_DIS];
   end
   // last access attempt, refused flag
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         space_q   <= `PPMC_SPACE_STD;
         refused_q <= 1'b0;
      end
      else if (wr_go)
      begin
         space_q   <= space_of(awaddr_q);
         refused_q <= ~wr_ok;
      end
      else if (rd_go)
      begin
         space_q   <= space_of(araddr_q);
         refused_q <= ~rd_ok;
      end
   end
   // pll-off spd exit triggers a full reset
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         pd_seen_q  <= 1'b0;
         pll_off_q  <= 1'b0;
         soft_rst_q <= 1'b0;
      end
      else
      begin
         pd_seen_q  <= spd_on;
         soft_rst_q <= 1'b0;
         if (spd_on && !pd_seen_q)
            pll_off_q <= spd_q[`PPMC_SPD_PLL];
         if (!spd_on && pd_seen_q)
         begin
            soft_rst_q <= pll_off_q;
            pll_off_q  <= 1'b0;
         end
      end
   end
   // strap taken once after reset release
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         strap_taken_q    <= 1'b0;
         settle_q         <= 2'd0;
         strap_chip_sleep <= 1'b0;
      end
      else if (!strap_taken_q)
      begin
         settle_q <= settle_q + 2'd1;
         if (settle_q == 2'd3)
         begin
            strap_taken_q    <= 1'b1;
            strap_chip_sleep <= (strap_s2_q == `PPMC_STRAP_SLEEP);
         end
      end
   end
   // ----------------------------------------
   // edpd link pulse timer
   // ----------------------------------------
   reg [15:0] pulse_cnt_q;
   reg [15:0] lfsr_q;
   wire [31:0] pulse_lim_w = `PPMC_PULSE_CYC << edpd_q[`PPMC_EDPD_TMR_LO +: 2];
   wire [15:0] pulse_lim = pulse_lim_w[15:0]; // longest interval fits 16 bits
   wire [15:0] jitter = edpd_q[`PPMC_EDPD_RAND] ? 16'h0000 : {8'h00, lfsr_q[7:0]};
   wire edpd_cond = edpd_q[`PPMC_EDPD_EN] & bctl_q[`PPMC_BCTL_AN] & ~link_sync & ~energy_sync;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         pulse_cnt_q <= 16'h0000;
         lfsr_q      <= 16'hace1;
         link_pulse  <= 1'b0;
      end
      else
      begin
         lfsr_q     <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         link_pulse <= 1'b0;
         if (!edpd_active)
            pulse_cnt_q <= {6'h00, edpd_q[`PPMC_EDPD_MASK_LO +: 2], 8'h00}; // mask hold-off
         else if (pulse_cnt_q >= pulse_lim + jitter)
         begin
            pulse_cnt_q <= 16'h0000;
            link_pulse  <= 1'b1;
         end
         else
            pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      end
   end
   // ----------------------------------------
   // power outputs
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         edpd_active                  <= 1'b0;
         tx_block_en                  <= 1'b1;
         rx_blocks_en                 <= 1'b1;
         int_clk_en                   <= 1'b1;
         pll_en                       <= 1'b1;
         xtal_en                      <= 1'b1;
         txrx_clk_en                  <= 1'b1;
         reference_clock_out_en       <= 1'b1;
         core_regulator_controller_en <= 1'b1;
         low_power_dsp                <= 1'b0;
      end
      else
      begin
         edpd_active  <= edpd_cond & ~spd_on;
         tx_block_en  <= ~spd_on & ~strap_chip_sleep;
         rx_blocks_en <= ~spd_on & ~strap_chip_sleep & ~edpd_cond;
         int_clk_en   <= (~spd_on | ovr) & ~strap_chip_sleep;
         pll_en       <= ~(spd_on & pll_off_q) & ~strap_chip_sleep;
         xtal_en      <= ~xtal_dis_q & ~strap_chip_sleep;
         txrx_clk_en  <= (~spd_on | ovr) & ~bctl_q[`PPMC_BCTL_ISO] & ~strap_chip_sleep;
         reference_clock_out_en <= (~spd_on | ovr) & clk125_en_q & ~strap_chip_sleep;
         core_regulator_controller_en <= ~reg_en_n_q;
         low_power_dsp <= link_sync & (len_s2_q < `PPMC_SHORT_M);
      end
   end
endmodule // ppmc_power_ctrl

// ---- dv/ppmc_power_ctrl_props.sv ----
`timescale 1ns/1ps
module ppmc_power_ctrl_props
(
   input wire clk,
   input wire sys_rst,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire link_up,
   input wire tx_block_en,
   input wire rx_blocks_en,
   input wire link_pulse,
   input wire int_clk_en,
   input wire pll_en,
   input wire xtal_en,
   input wire txrx_clk_en,
   input wire reference_clock_out_en,
   input wire strap_chip_sleep,
   input wire edpd_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_link_held;
      link_up [*5];
   endsequence
   // bus answers and power states
   a_read_answer: assert property (s_rd_taken |-> ##2 s_axi_rvalid) else $error("read answer late");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_edpd_link_off: assert property (s_link_held |-> !edpd_active) else $error("edpd with link");
   a_edpd_blocks: assert property (edpd_active |-> tx_block_en && !rx_blocks_en) else $error("edpd blocks");
   a_pulse_in_edpd: assert property (link_pulse |-> edpd_active) else $error("pulse outside edpd");
   a_pll_off_gated: assert property (!pll_en |-> !int_clk_en) else $error("clocks without pll");
   a_xtal_after_pll: assert property (!xtal_en |-> !pll_en) else $error("crystal off before pll");
   a_xtal_locked: assert property ($fell(xtal_en) |=> !xtal_en [*8]) else $error("crystal came back");
   a_gate_txrx: assert property (!int_clk_en |-> !txrx_clk_en) else $error("txrx clocks run gated");
   a_gate_refclk: assert property (!int_clk_en |-> !reference_clock_out_en) else $error("refclk runs gated");
   a_sleep_held: assert property (strap_chip_sleep |=> strap_chip_sleep) else $error("chip sleep left");
endmodule // ppmc_power_ctrl_props

bind ppmc_power_ctrl ppmc_power_ctrl_props i_props (.*);

// ---- dv/ppmc_host_model.sv ----
`timescale 1ns/1ps
module ppmc_host_model
(
   input  wire        clk,
   output reg  [11:0] s_axi_awaddr,
   output reg         s_axi_awvalid,
   input  wire        s_axi_awready,
   output reg  [31:0] s_axi_wdata,
   output reg  [3:0]  s_axi_wstrb,
   output reg         s_axi_wvalid,
   input  wire        s_axi_wready,
   input  wire [1:0]  s_axi_bresp,
   input  wire        s_axi_bvalid,
   output reg         s_axi_bready,
   output reg  [11:0] s_axi_araddr,
   output reg         s_axi_arvalid,
   input  wire        s_axi_arready,
   input  wire [31:0] s_axi_rdata,
   input  wire [1:0]  s_axi_rresp,
   input  wire        s_axi_rvalid,
   output reg         s_axi_rready
);
   // idle bus at time zero
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
   end
   // one write, address and data offered together
   task wr(input [11:0] a, input [31:0] d, output [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready && s_axi_awvalid)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a; // released lines carry no stale value
      s_axi_wdata <= ~d;
   endtask
   // one read
   task rd(input [11:0] a, output [31:0] d, output [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready && s_axi_arvalid)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
   endtask
endmodule // ppmc_host_model

// ---- dv/ppmc_power_ctrl_bench.sv ----
`timescale 1ns/1ps
module ppmc_power_ctrl_bench;
   reg         clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         link_up = 1'b1;
   reg         energy_seen = 1'b0;
   reg  [3:0]  mode_strap = 4'h0;
   reg  [7:0]  cable_len_m = 8'd100;
   wire [11:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, link_pulse, xtal_en;
   wire        tx_block_en, rx_blocks_en, int_clk_en, pll_en, txrx_clk_en, reference_clock_out_en;
   wire        core_regulator_controller_en, low_power_dsp, strap_chip_sleep, edpd_active;
   wire [9:0]  pins = {edpd_active, rx_blocks_en, tx_block_en, int_clk_en, pll_en, txrx_clk_en,
                       reference_clock_out_en, core_regulator_controller_en, low_power_dsp, strap_chip_sleep};
   localparam [9:0] ED = 10'h200, RX = 10'h100, TX = 10'h080, IC = 10'h040, PL = 10'h020;
   localparam [9:0] TR = 10'h010, RF = 10'h008, RG = 10'h004, LP = 10'h002, SL = 10'h001;
   int         fails = 0, n_compared = 0, cyc = 0, t, pll_e, dead = 0;
   int         mdl [0:5];
   int         msk [0:5] = '{'h1c00, 'h3f, 'h3, 'h1, 'h1, 'h1};
   int         regs_q [$] = '{0, 1, 2, 3, 4, 5};
   logic [31:0] rd_d;
   logic [1:0] rd_r, wr_r;

   ppmc_power_ctrl i_dut (.*);
   ppmc_host_model i_host (.*);

   always #4 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         fails = fails + 1;
         finish_test();
      end
   end
   // ----------------------------------------
   // model and compares
   // ----------------------------------------
   task finish_test;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_pins(input [9:0] m, input [9:0] e, input int lim);
      t = 0;
      while ((pins & m) !== e && t < lim)
      begin
         @(posedge clk);
         t = t + 1;
      end
      chk("power pins", e, pins & m);
   endtask
   task mdl_reset;
      mdl = '{'h1000, 0, 0, 0, 0, 1};
      pll_e = 0;
   endtask
   function automatic int okay(int i);
      okay = !dead && i <= 5 && !(mdl[0][11] && (i == 2 || i == 4 || i == 1 && !mdl[2][0]));
   endfunction
   task mwr(input int i, input int d);
      int ok;
      int rst;
      ok = okay(i);
      rst = 0;
      i_host.wr(12'(i * 4), d, wr_r);
      chk("write resp", ok ? 0 : 2, wr_r);
      if (ok)
      begin
         if (i == 3 && !(pll_e && mdl[0][11]))
            d = 0; // crystal write ignored outside pll-off spd
         dead = dead | (i == 3 && d[0]);
         if (i == 0 && d[11] && !mdl[0][11])
            pll_e = mdl[2][1];
         rst = i == 0 && !d[11] && mdl[0][11] && pll_e;
         mdl[i] = d & msk[i];
         if (rst)
            mdl_reset();
      end
      repeat (4) @(posedge clk);
   endtask
   task mrd(input int i);
      int ok;
      ok = okay(i);
      i_host.rd(12'(i * 4), rd_d, rd_r);
      chk("read resp", ok ? 0 : 2, rd_r);
      chk("read data", ok ? mdl[i] : 0, rd_d);
   endtask
   task rd_all;
      foreach (regs_q[k])
         mrd(regs_q[k]);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      t = $urandom(26);
      mdl_reset();
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      rd_all();
      mrd(8);
      chk_pins(10'h3ff, IC | PL | TR | RF | RG | TX | RX, 1);
      mwr(1, ($urandom & 'h3e) | 1);
      mrd(1);
      link_up <= 1'b0;
      chk_pins(ED | RX | TX, ED | TX, 50);
      t = 0;
      while (!link_pulse && t < 17000)
      begin
         @(posedge clk);
         t = t + 1;
      end
      chk("link pulse", 1, link_pulse);
      link_up <= 1'b1;
      chk_pins(ED | RX, RX, 50);
      rd_all();
      mwr(0, 0);
      link_up <= 1'b0;
      repeat (40) @(posedge clk);
      chk_pins(ED, 0, 1);
      energy_seen <= 1'b1;
      mwr(0, 'h1000);
      repeat (40) @(posedge clk);
      chk_pins(ED, 0, 1);
      energy_seen <= 1'b0;
      link_up <= 1'b1;
      mwr(0, 'h1800);
      chk_pins(IC | TR | RF | PL | RX, PL, 20);
      rd_all();
      mwr(1, 0);
      mwr(0, 'h1000);
      chk_pins(IC | TR | RF, IC | TR | RF, 20);
      rd_all();
      mwr(2, 1);
      mwr(0, 'h1800);
      chk_pins(IC | TR | RF, IC | TR | RF, 20);
      rd_all();
      mwr(0, 'h1c00);
      chk_pins(TR, 0, 20);
      mwr(0, 'h1000);
      mwr(5, 0);
      chk_pins(RF, 0, 20);
      mwr(5, 1);
      mwr(4, 1);
      chk_pins(RG, 0, 20);
      mwr(4, 0);
      chk_pins(RG, RG, 20);
      mwr(1, 'h15);
      mwr(2, 2);
      mwr(0, 'h1800);
      chk_pins(PL | IC, 0, 20);
      mwr(0, 'h1000);
      chk_pins(PL | IC, PL | IC, 20);
      rd_all();
      mwr(2, 2);
      mwr(0, 'h1800);
      mwr(3, 1);
      chk("crystal enable", 0, xtal_en);
      mrd(0);
      cable_len_m <= 8'd69;
      chk_pins(LP, LP, 20);
      @(posedge clk);
      cable_len_m <= 8'd70;
      chk_pins(LP, 0, 20);
      @(posedge clk);
      cable_len_m <= 8'($urandom % 70);
      chk_pins(LP, LP, 20);
      @(posedge clk);
      mode_strap <= 4'h7;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      mdl_reset();
      dead = 1;
      chk_pins(SL, SL, 20);
      @(posedge clk);
      mode_strap <= 4'h0;
      repeat (20) @(posedge clk);
      chk_pins(SL, SL, 1);
      mrd(0);
      finish_test();
   end
endmodule // ppmc_power_ctrl_bench
